/* common/sdmc_pkg.sv */
// Constants shared by the stall detector switch decoder and countdown block
//============================================================================
// What this block does
// - Integrate clear opens all eight routing switches
// - Integrate set closes the tabled switch pair
// - Underflow enable gates underflow flag onto interrupt
// - Without reload mode, count down, halt at zero
// - Reload mode reloads latest reload value at zero
// - Read select picks live count or reload
// - Prescale bit picks divide by 64 or 512
// - New prescale takes effect at next load
// - Force-load bit copies reload now if the counter was already enabled, reads zero
// - Counter disabled holds count at all ones
// - Overflow enable gates overflow flag onto interrupt
// - Underflow flag set at zero, write-one clears
// - Accumulator overflow sets flag, write-one clears
// - Writing zero to count sets no flag
// - With counter enabled and no reload mode, count write loads both
//============================================================================
package sdmc_pkg;

	// Register offsets (byte addresses)
	localparam logic [2:0] OFS_HOME_CTL  = 3'h0;
	localparam logic [2:0] OFS_COUNT_CTL = 3'h1;
	localparam logic [2:0] OFS_STALL_CTL = 3'h2;
	localparam logic [2:0] OFS_FLAGS     = 3'h3;
	localparam logic [2:0] OFS_COUNT_HI  = 3'h4;
	localparam logic [2:0] OFS_COUNT_LO  = 3'h5;
	localparam logic [2:0] OFS_ACC_HI    = 3'h6;
	localparam logic [2:0] OFS_ACC_LO    = 3'h7;

	// Return-home control fields
	localparam int HC_INTEGRATE = 7;
	localparam int HC_DRIVE     = 6;
	localparam int HC_NODE_SWAP = 4;
	localparam int HC_MOTOR_SEL = 2;
	localparam int HC_STEP_LSB  = 0;
	localparam logic [7:0] HC_WMASK = 8'hf7;

	// Countdown control fields
	localparam int CC_UF_IRQ_EN   = 7;
	localparam int CC_RELOAD_MODE = 6;
	localparam int CC_READ_RELOAD = 5;
	localparam int CC_PRESCALE    = 4;
	localparam int CC_FORCE       = 3;
	localparam int CC_COUNTER_EN  = 2;
	localparam int CC_AO_IRQ_EN   = 0;
	localparam logic [7:0] CC_WMASK = 8'hf5;

	// Stall control fields
	localparam int SC_RETURN_HOME = 7;
	localparam logic [7:0] SC_WMASK = 8'he3;

	// Flag positions (same layout as the enables in countdown control)
	localparam int FL_UNDERFLOW = 7;
	localparam int FL_ACC_OVF   = 0;

	// Reset values
	localparam logic [7:0]  CTL_RESET    = 8'h00;
	localparam logic [15:0] COUNT_PRESET = 16'hffff;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;

	// Prescale division rates
	localparam int DIV_FAST = 64;
	localparam int DIV_SLOW = 512;

endpackage

/* rtl/sdmc_top.sv */
// Stall detector switch routing, coil drive selection and countdown timer
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module sdmc_top
#(
	parameter int DIV_FAST = sdmc_pkg::DIV_FAST,
	parameter int DIV_SLOW = sdmc_pkg::DIV_SLOW
)
(
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_CE,
	input  wire logic [2:0]  I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	input  wire logic        I_ACC_OVF,
	input  wire logic [15:0] I_ACC_VALUE,
	output logic      [7:0]  O_RDATA,
	output logic             O_IRQ,
	output logic      [7:0]  O_SWITCH,
	output logic             O_SINE_POS,
	output logic             O_SINE_NEG,
	output logic             O_COSINE_POS,
	output logic             O_COSINE_NEG,
	output logic             O_MOTOR_SEL,
	output logic             O_RETURN_HOME_EN
);

	//========================================================================
	// Elaboration checks
	localparam int PRE_W = $clog2(DIV_SLOW);

	if (DIV_FAST < 2 || DIV_SLOW < DIV_FAST)
	begin : g_bad_div
		$error("Prescale divisors must satisfy 2 <= fast <= slow");
	end

	//========================================================================
	// Functions

	// Switch pattern, bit 0 is switch 1
	function automatic logic [7:0] sw_decode(
		input logic       integ,
		input logic [1:0] step,
		input logic       swap
	);
		logic [7:0] pat;
		pat = 8'h00;
		if (integ)
		begin
			case (step)
				2'h0: pat = swap ? 8'h60 : 8'h90;
				2'h1: pat = swap ? 8'h09 : 8'h06;
				2'h2: pat = swap ? 8'h90 : 8'h60;
				2'h3: pat = swap ? 8'h06 : 8'h09;
				default: pat = 8'h00;
			endcase
		end
		return pat;
	endfunction

	// Byte of a 16-bit word, high when hi is set
	function automatic logic [7:0] byte_of(
		input logic [15:0] w,
		input logic        hi
	);
		return hi ? w[15:8] : w[7:0];
	endfunction

	//========================================================================
	// State
	logic [7:0]       home_ctl_q;   // Return-home control
	logic [7:0]       count_ctl_q;  // Countdown control
	logic [7:0]       stall_ctl_q;  // Stall control
	logic             uf_flag_q;    // Underflow flag
	logic             ao_flag_q;    // Accumulator overflow flag
	logic [15:0]      count_q;      // Live count
	logic [15:0]      reload_q;     // Reload value
	logic [7:0]       hi_hold_q;    // High byte waiting for low byte
	logic [PRE_W-1:0] pre_cnt_q;    // Prescale cycle counter
	logic             pre_slow_q;   // Active prescale selection

	//========================================================================
	// Bus decode
	wire wr_home   = I_WR && (I_ADDR == sdmc_pkg::OFS_HOME_CTL);
	wire wr_cctl   = I_WR && (I_ADDR == sdmc_pkg::OFS_COUNT_CTL);
	wire wr_stall  = I_WR && (I_ADDR == sdmc_pkg::OFS_STALL_CTL);
	wire wr_flags  = I_WR && (I_ADDR == sdmc_pkg::OFS_FLAGS);
	wire wr_cnt_hi = I_WR && (I_ADDR == sdmc_pkg::OFS_COUNT_HI);
	wire wr_cnt_lo = I_WR && (I_ADDR == sdmc_pkg::OFS_COUNT_LO);

	// Control byte as it stands after this cycle's write
	wire [7:0] cctl_new = wr_cctl ? (I_WDATA & sdmc_pkg::CC_WMASK)
	                              : count_ctl_q;

	// Written 16-bit count word, committed on the low byte
	wire [15:0] cnt_word = {hi_hold_q, I_WDATA};

	// Control fields
	wire counter_en  = count_ctl_q[sdmc_pkg::CC_COUNTER_EN];
	wire reload_mode = count_ctl_q[sdmc_pkg::CC_RELOAD_MODE];
	wire read_reload_sel = count_ctl_q[sdmc_pkg::CC_READ_RELOAD];
	wire force_reload = wr_cctl && I_WDATA[sdmc_pkg::CC_FORCE];

	//========================================================================
	// Prescaler tick
	wire [PRE_W-1:0] div_last = pre_slow_q ? PRE_W'(DIV_SLOW - 1)
	                                       : PRE_W'(DIV_FAST - 1);
	wire tick = (pre_cnt_q == div_last);

	//========================================================================
	// Counter next state
	logic [15:0] count_d;
	logic [15:0] reload_d;
	logic        load_evt;   // Reload value moved into count
	logic        uf_set;     // Counter reached zero by counting

	always_comb
	begin
		count_d  = count_q;
		reload_d = reload_q;
		load_evt = 1'b0;
		uf_set   = 1'b0;
		// Count writes always update the reload value
		if (wr_cnt_lo)
		begin
			reload_d = cnt_word;
		end
		if (!counter_en)
		begin
			count_d = sdmc_pkg::COUNT_PRESET;
		end
		else if (force_reload)
		begin
			count_d  = reload_q;
			load_evt = 1'b1;
		end
		else if (wr_cnt_lo && !reload_mode)
		begin
			count_d  = cnt_word;
			load_evt = 1'b1;
		end
		else if (tick && count_q != 16'h0000)
		begin
			if (count_q == 16'h0001)
			begin
				uf_set = 1'b1;
				if (reload_mode)
				begin
					count_d  = reload_q;
					load_evt = 1'b1;
				end
				else
				begin
					count_d = 16'h0000;
				end
			end
			else
			begin
				count_d = count_q - 16'h0001;
			end
		end
	end

	// Flags: a set in the same cycle as a clear wins
	wire uf_d = uf_set || (uf_flag_q && !(wr_flags &&
	            I_WDATA[sdmc_pkg::FL_UNDERFLOW]));
	wire ao_d = I_ACC_OVF || (ao_flag_q && !(wr_flags &&
	            I_WDATA[sdmc_pkg::FL_ACC_OVF]));

	// Interrupt request from the post-update flags and enables
	wire irq_d = (uf_d && cctl_new[sdmc_pkg::CC_UF_IRQ_EN])
	          || (ao_d && cctl_new[sdmc_pkg::CC_AO_IRQ_EN]);

	//========================================================================
	// Read data selection
	wire [15:0] count_view = read_reload_sel ? reload_q : count_q;
	wire [7:0] flags_view = {uf_flag_q, 6'h00, ao_flag_q};
	logic [7:0] rdata_d;

	always_comb
	begin
		case (I_ADDR)
			sdmc_pkg::OFS_HOME_CTL:  rdata_d = home_ctl_q;
			sdmc_pkg::OFS_COUNT_CTL: rdata_d = count_ctl_q; // force bit is 0
			sdmc_pkg::OFS_STALL_CTL: rdata_d = stall_ctl_q;
			sdmc_pkg::OFS_FLAGS:     rdata_d = flags_view;
			sdmc_pkg::OFS_COUNT_HI:  rdata_d = byte_of(count_view, 1'b1);
			sdmc_pkg::OFS_COUNT_LO:  rdata_d = byte_of(count_view, 1'b0);
			sdmc_pkg::OFS_ACC_HI:    rdata_d = byte_of(I_ACC_VALUE, 1'b1);
			sdmc_pkg::OFS_ACC_LO:    rdata_d = byte_of(I_ACC_VALUE, 1'b0);
			default:                 rdata_d = 8'h00;
		endcase
	end

	//========================================================================
	// Output decode
	wire [1:0] step = home_ctl_q[sdmc_pkg::HC_STEP_LSB +: 2];
	wire [7:0] sw_d = sw_decode(home_ctl_q[sdmc_pkg::HC_INTEGRATE], step,
	                            home_ctl_q[sdmc_pkg::HC_NODE_SWAP]);
	wire drive = home_ctl_q[sdmc_pkg::HC_DRIVE]
	          && stall_ctl_q[sdmc_pkg::SC_RETURN_HOME];

	//========================================================================
	// Registers: control and flags
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			home_ctl_q  <= sdmc_pkg::CTL_RESET;
			count_ctl_q <= sdmc_pkg::CTL_RESET;
			stall_ctl_q <= sdmc_pkg::CTL_RESET;
			uf_flag_q   <= 1'b0;
			ao_flag_q   <= 1'b0;
			hi_hold_q   <= 8'h00;
		end
		else if (I_CE)
		begin
			if (wr_home)
				home_ctl_q <= I_WDATA & sdmc_pkg::HC_WMASK;
			count_ctl_q <= cctl_new;
			if (wr_stall)
				stall_ctl_q <= I_WDATA & sdmc_pkg::SC_WMASK;
			uf_flag_q <= uf_d;
			ao_flag_q <= ao_d;
			if (wr_cnt_hi)
				hi_hold_q <= I_WDATA;
		end
	end

	//========================================================================
	// Registers: counter and prescaler
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			count_q    <= sdmc_pkg::COUNT_PRESET;
			reload_q   <= sdmc_pkg::RELOAD_RESET;
			pre_cnt_q  <= '0;
			pre_slow_q <= 1'b0;
		end
		else if (I_CE)
		begin
			count_q  <= count_d;
			reload_q <= reload_d;
			// Restart the prescaler when idle or on every load
			if (!counter_en || load_evt || tick)
				pre_cnt_q <= '0;
			else
				pre_cnt_q <= pre_cnt_q + PRE_W'(1);
			if (load_evt)
				pre_slow_q <= cctl_new[sdmc_pkg::CC_PRESCALE];
		end
	end

	//========================================================================
	// Registered outputs
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			O_RDATA          <= 8'h00;
			O_IRQ            <= 1'b0;
			O_SWITCH         <= 8'h00;
			O_SINE_POS       <= 1'b0;
			O_SINE_NEG       <= 1'b0;
			O_COSINE_POS     <= 1'b0;
			O_COSINE_NEG     <= 1'b0;
			O_MOTOR_SEL      <= 1'b0;
			O_RETURN_HOME_EN <= 1'b0;
		end
		else if (I_CE)
		begin
			// Read data stands only in the cycle after the strobe
			O_RDATA          <= I_RD ? rdata_d : 8'h00;
			O_IRQ            <= irq_d;
			O_SWITCH         <= sw_d;
			O_SINE_POS       <= drive && (step == 2'h0);
			O_SINE_NEG       <= drive && (step == 2'h2);
			O_COSINE_POS     <= drive && (step == 2'h1);
			O_COSINE_NEG     <= drive && (step == 2'h3);
			O_MOTOR_SEL      <= home_ctl_q[sdmc_pkg::HC_MOTOR_SEL];
			O_RETURN_HOME_EN <= stall_ctl_q[sdmc_pkg::SC_RETURN_HOME];
		end
	end

endmodule

`default_nettype wire

/* test/sdmc_props.sv */
// Port checker for the switch decoder and countdown block
`timescale 1ns/10ps
`default_nettype none
module sdmc_props
#(
	parameter int DIV_FAST = 64,
	parameter int DIV_SLOW = 512
)
(
	input wire logic        I_CORE_CLK,
	input wire logic        I_RST,
	input wire logic        I_CE,
	input wire logic [2:0]  I_ADDR,
	input wire logic [7:0]  I_WDATA,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic        I_ACC_OVF,
	input wire logic [15:0] I_ACC_VALUE,
	input wire logic [7:0]  O_RDATA,
	input wire logic        O_IRQ,
	input wire logic [7:0]  O_SWITCH,
	input wire logic        O_SINE_POS,
	input wire logic        O_SINE_NEG,
	input wire logic        O_COSINE_POS,
	input wire logic        O_COSINE_NEG,
	input wire logic        O_MOTOR_SEL,
	input wire logic        O_RETURN_HOME_EN
);
	//==========================================================
	// Mirrors of written control bits
	logic [7:0] hc_q;    // Home control
	logic [7:0] cc_q;    // Countdown control as stored
	logic       rh_q;    // Return home enable
	logic [1:0] quiet_q; // Cycles since last write
	wire        settled = quiet_q[1];
	wire  [3:0] coils = {O_SINE_POS, O_SINE_NEG,
		O_COSINE_POS, O_COSINE_NEG};
	// One-hot coil: step 0 sine+, 1 cos+, 2 sine-, 3 cos-
	wire  [3:0] coil_exp = (hc_q[6] && rh_q) ?
		4'h1 << {~hc_q[0], ~hc_q[1]} : 4'h0;

	// Closed switch pair for {step, swap}
	function automatic logic [7:0] sw_f(input logic [2:0] k);
		case (k)
			3'h0, 3'h5: sw_f = 8'h90;
			3'h1, 3'h4: sw_f = 8'h60;
			3'h2, 3'h7: sw_f = 8'h06;
			default:    sw_f = 8'h09;
		endcase
	endfunction

	// Follow what software wrote
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			hc_q    <= 8'h00;
			cc_q    <= 8'h00;
			rh_q    <= 1'b0;
			quiet_q <= 2'h0;
		end
		else if (I_CE)
		begin
			if (I_WR && I_ADDR == 3'h0)
				hc_q <= I_WDATA;
			if (I_WR && I_ADDR == 3'h1)
				cc_q <= I_WDATA & sdmc_pkg::CC_WMASK;
			if (I_WR && I_ADDR == 3'h2)
				rh_q <= I_WDATA[7];
			if (I_WR)
				quiet_q <= 2'h0;
			else if (!settled)
				quiet_q <= quiet_q + 2'h1;
		end
	end

	//==========================================================
	// Properties
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RST);
	sequence s_rd_ctl;
		I_CE && I_RD && I_ADDR == 3'h1;
	endsequence
	a_switch_open: assert property (settled && !hc_q[7] |-> O_SWITCH == 8'h00)
		else $error("switch closed with integrate off");
	a_switch_pair: assert property (settled && hc_q[7] |-> O_SWITCH == sw_f({hc_q[1:0], hc_q[4]}))
		else $error("wrong switch pair");
	a_coil_drive: assert property (settled |-> coils == coil_exp)
		else $error("wrong coil drive");
	a_ovf_irq: assert property (I_CE && I_ACC_OVF && cc_q[0] |-> ##[1:2] O_IRQ)
		else $error("overflow raised no interrupt");
	a_irq_masked: assert property (settled && (cc_q & 8'h81) == 8'h00 |-> !O_IRQ)
		else $error("interrupt while masked");
	a_rdata_idle: assert property (I_CE && !I_RD |=> O_RDATA == 8'h00)
		else $error("read data outside read cycle");
	a_ctl_readback: assert property (s_rd_ctl |=> O_RDATA == cc_q)
		else $error("control readback wrong");
	a_idle_preset: assert property (I_CE && I_RD && I_ADDR[2:1] == 2'h2 && !cc_q[5] && !cc_q[2] && !$past(cc_q[2]) |=> O_RDATA == 8'hff)
		else $error("disabled count not all ones");
endmodule

bind sdmc_top sdmc_props #(.DIV_FAST(DIV_FAST), .DIV_SLOW(DIV_SLOW)) u_props (
	.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_ACC_OVF(I_ACC_OVF),
	.I_ACC_VALUE(I_ACC_VALUE), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
	.O_SWITCH(O_SWITCH), .O_SINE_POS(O_SINE_POS), .O_SINE_NEG(O_SINE_NEG),
	.O_COSINE_POS(O_COSINE_POS), .O_COSINE_NEG(O_COSINE_NEG),
	.O_MOTOR_SEL(O_MOTOR_SEL), .O_RETURN_HOME_EN(O_RETURN_HOME_EN));
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the switch decoder and countdown block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module tb;
	logic       clk = 1'b0;    // Core clock, 100 ns
	logic       rst = 1'b1;    // Synchronous reset
	logic [2:0] addr = 3'h0;   // Register address
	logic [7:0] wdata = 8'h00; // Write data
	logic       wr_s = 1'b0;   // Write strobe
	logic       rd_s = 1'b0;   // Read strobe
	logic       ovf = 1'b0;    // Accumulator overflow pulse
	logic [7:0] rdata;
	logic       irq;
	logic [7:0] sw;
	logic       home_en;
	logic       motor;         // Motor select output
	int         err_count = 0;
	int         compares = 0;
	int         cyc = 0;       // Free cycle count for timing
	int         t0;

	// Short prescale so underflows come quickly
	sdmc_top #(.DIV_FAST(8), .DIV_SLOW(32)) u_sdmc_top (
		.I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .I_ACC_OVF(ovf),
		.I_ACC_VALUE(16'ha5c3), .O_RDATA(rdata), .O_IRQ(irq),
		.O_SWITCH(sw), .O_SINE_POS(), .O_SINE_NEG(), .O_COSINE_POS(),
		.O_COSINE_NEG(), .O_MOTOR_SEL(motor), .O_RETURN_HOME_EN(home_en));

	initial
	begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
		cyc <= cyc + 1;

	//==========================================================
	// Bus cycles and waits
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Wait for the interrupt and judge the elapsed cycles
	task automatic wait_irq(input int lo, input int hi);
		int n;
		n = 0;
		// Let a clear written at the last edge reach the output first
		#1;
		while (irq !== 1'b1 && n < 1000)
		begin
			idle(1);
			n++;
		end
		`CHK(cyc - t0 >= lo && cyc - t0 <= hi, 1'b1)
	endtask

	//==========================================================
	// Scenarios
	task automatic t_reset;
		rd(3'h1, 8'h00);
		rd(3'h4, 8'hff);
		rd(3'h3, 8'h00);
		rd(3'h6, 8'ha5);
		rd(3'h7, 8'hc3);
	endtask
	task automatic t_switch;
		wr(3'h2, 8'h80);
		for (int i = 0; i < 32; i++)
		begin
			wr(3'h0, {i[4], i[3], 1'b0, i[2], 2'h0, i[1:0]});
			idle(3);
		end
		wr(3'h0, 8'h80);
		idle(3);
		`CHK(sw, 8'h90)
		`CHK(home_en, 1'b1)
		wr(3'h0, 8'h13);
		idle(3);
		`CHK(sw, 8'h00)
		`CHK(motor, 1'b0)
		wr(3'h0, 8'h04);
		idle(3);
		`CHK(motor, 1'b1)
		`CHK(sw, 8'h00)
	endtask
	task automatic t_oneshot;
		wr(3'h1, 8'h84);
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h03);
		t0 = cyc;
		rd(3'h5, 8'h03);
		wait_irq(20, 28);
		idle(30);
		rd(3'h5, 8'h00);
		rd(3'h3, 8'h80);
		wr(3'h3, 8'h00);
		rd(3'h3, 8'h80);
		wr(3'h3, 8'h80);
		rd(3'h3, 8'h00);
		`CHK(irq, 1'b0)
	endtask
	task automatic t_prescale;
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h04);
		t0 = cyc;
		wr(3'h1, 8'h94);
		wait_irq(28, 36);
		wr(3'h3, 8'h80);
		wr(3'h1, 8'h9c);
		t0 = cyc;
		rd(3'h1, 8'h94);
		wait_irq(124, 132);
	endtask
	task automatic t_reload;
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h80);
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h02);
		rd(3'h5, 8'hff);
		wr(3'h1, 8'h20);
		rd(3'h5, 8'h02);
		wr(3'h1, 8'hc4);
		wr(3'h1, 8'hcc);
		t0 = cyc;
		wait_irq(12, 20);
		wr(3'h3, 8'h80);
		t0 = cyc;
		wait_irq(1, 20);
	endtask
	task automatic t_zero;
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h81);
		wr(3'h1, 8'h84);
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h00);
		idle(40);
		rd(3'h3, 8'h00);
		rd(3'h5, 8'h00);
	endtask
	task automatic t_ovf;
		wr(3'h1, 8'h00);
		@(posedge clk);
		ovf <= 1'b1;
		@(posedge clk);
		ovf <= 1'b0;
		idle(2);
		`CHK(irq, 1'b0)
		rd(3'h3, 8'h01);
		wr(3'h3, 8'h01);
		rd(3'h3, 8'h00);
		wr(3'h1, 8'h01);
		@(posedge clk);
		ovf <= 1'b1;
		@(posedge clk);
		ovf <= 1'b0;
		idle(2);
		`CHK(irq, 1'b1)
		wr(3'h3, 8'h01);
		idle(2);
		`CHK(irq, 1'b0)
	endtask

	task automatic finish_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence after ten cycles of reset
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_switch;
		t_oneshot;
		t_prescale;
		t_reload;
		t_zero;
		t_ovf;
		finish_test;
	end
	// Watchdog well past the expected run length
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test;
	end
endmodule
`default_nettype wire
